//--- rtl/integrity_pkg.sv
/*
  constants for the reset sequencer and integrity block: register map,
  field positions, reset values, sequence timing.
  assumes a 40 MHz cpu clock and a single 32-bit AHB-Lite master.
*/
package integrity_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  // least width of the reset pin pulse that the device drives
  localparam int RST_OUT_MIN_NS = 20000;
  localparam int RST_OUT_MIN_CYC =
    (RST_OUT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACT_CNT_W = 12;
  localparam logic [ACT_CNT_W-1:0] ACT_LAST =
    ACT_CNT_W'(RST_OUT_MIN_CYC - 1);

  // stabilisation delay lengths in cpu cycles
  localparam int DLY_CNT_W = 13;
  localparam logic [DLY_CNT_W-1:0] DLY_SHORT = 13'h0100;
  localparam logic [DLY_CNT_W-1:0] DLY_LONG = 13'h1000;

  // vector fetch: two cycles at the top word pair
  localparam logic [15:0] VEC_ADDR_LO = 16'hFFFE;
  localparam logic [15:0] VEC_ADDR_HI = 16'hFFFF;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] INTEGRITY_CTRL_STATUS_OFS = 8'h00;
  localparam logic [7:0] INTEGRITY_CTRL_STATUS_RST = 8'h00;

  // integrity_ctrl_status fields
  localparam int WDG_RF_BIT = 0;
  localparam int SAFE_ACT_BIT = 1;
  localparam int SAFE_IE_BIT = 2;
  localparam int LVD_RF_BIT = 4;
  localparam int WARN_FLAG_BIT = 5;
  localparam int WARN_IE_BIT = 6;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_RUN = 2'b00,
    SEQ_ACTIVE = 2'b01,
    SEQ_DELAY = 2'b10,
    SEQ_FETCH = 2'b11
  } seq_state_t;

endpackage

//--- rtl/reset_and_integrity_manager.sv
/*
  reset sequencer plus supply warning and clock security logic, with an
  AHB-Lite slave for the integrity control and status register.
  assumes: analog comparators, clock detector and clock mux sit outside;
  option inputs are static straps; the reset pin is open-drain with an
  external pull-up, resolved by the surrounding wiring.
*/
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps

module reset_and_integrity_manager #(
  parameter int HADDR_W = 32
) (
  // clock and power-on reset
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  // AHB-Lite slave
  input wire logic HSEL_IN,
  input wire logic [HADDR_W-1:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // reset pin, open-drain
  input wire logic RST_PIN_IN,
  output logic RST_PIN_OUT,
  output logic RST_PIN_OE_OUT,
  // reset sources and option straps
  input wire logic WDOG_UNDERFLOW_IN,
  input wire logic LVD_RESET_IN,
  input wire logic OPT_LVD_EN_IN,
  input wire logic OPT_LONG_DELAY_IN,
  input wire logic OPT_CSS_EN_IN,
  input wire logic OPT_PLL_EN_IN,
  // supply warning comparator and clock detector
  input wire logic AVD_CMP_IN,
  input wire logic MAIN_CLK_OK_IN,
  // interrupt service and power mode
  input wire logic WARN_IRQ_ACK_IN,
  input wire logic DEEP_STOP_IN,
  // core side
  output logic CORE_RST_OUT,
  output logic VEC_FETCH_OUT,
  output logic [15:0] VEC_ADDR_OUT,
  output logic WARN_IRQ_OUT,
  output logic SAFE_IRQ_OUT,
  output logic WAKE_OUT,
  output logic SAFE_CLK_SEL_OUT,
  output logic GLITCH_FILT_EN_OUT
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  generate
    if (HADDR_W < 8) begin : g_bad_aw
      $error("HADDR_W must be at least 8");
    end
  endgenerate

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    integrity_pkg::seq_state_t state;
    logic [integrity_pkg::ACT_CNT_W-1:0] act_cnt;
    logic [integrity_pkg::DLY_CNT_W-1:0] dly_cnt;
    logic fetch_second;
    logic pin_oe;
    logic core_rst;
    logic vec_fetch;
    logic [15:0] vec_addr;
    logic lvd_s1;
    logic lvd_s2;
    logic avd_s1;
    logic avd_s2;
    logic clk_s1;
    logic clk_s2;
    logic wdg_rf;
    logic lvd_rf;
    logic warn_ie;
    logic safe_ie;
    logic safe_act;
    logic safe_sel;
    logic warn_prev;
    logic warn_pend;
    logic wr_pend;
    logic wr_hit;
    logic [7:0] rdata;
  } regs_t;

  regs_t cur_ff;
  regs_t nxt_ff;
  logic ext_s1_ff;
  logic ext_s2_ff;
  logic ext_arst_n;

  // delay length chosen by the option strap
  function automatic logic [integrity_pkg::DLY_CNT_W-1:0] dly_len(
    input logic long_sel
  );
    dly_len = long_sel ? integrity_pkg::DLY_LONG : integrity_pkg::DLY_SHORT;
  endfunction

  // register hit decode on the low address byte
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == integrity_pkg::INTEGRITY_CTRL_STATUS_OFS);
  endfunction

  // ----------------------------------------------------------------
  // external reset pin capture
  // ----------------------------------------------------------------
  // a low pin clears both stages at once, no clock needed; the release
  // is resynchronised so the sequencer sees a clean level
  assign ext_arst_n = RSTN_IN & RST_PIN_IN;

  // asynchronous low capture, synchronous release
  always_ff @(posedge MCLK_IN or negedge ext_arst_n) begin
    if (!ext_arst_n) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
    end else begin
      ext_s1_ff <= 1'b1;
      ext_s2_ff <= ext_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic lvd_act;
  logic warn_flag;
  logic addr_ok;
  logic src_ext;
  logic src_wdg;
  logic start_seq;
  logic [7:0] status_val;

  always_comb begin
    nxt_ff = cur_ff;
    // synchronisers for the analog levels
    nxt_ff.lvd_s1 = LVD_RESET_IN;
    nxt_ff.lvd_s2 = cur_ff.lvd_s1;
    nxt_ff.avd_s1 = AVD_CMP_IN;
    nxt_ff.avd_s2 = cur_ff.avd_s1;
    nxt_ff.clk_s1 = MAIN_CLK_OK_IN;
    nxt_ff.clk_s2 = cur_ff.clk_s1;

    // low-voltage source exists only with its option
    lvd_act = cur_ff.lvd_s2 & OPT_LVD_EN_IN;
    // warning flag follows the comparator, only with that option
    warn_flag = cur_ff.avd_s2 & OPT_LVD_EN_IN;

    // pin is our own output outside run, so it is only a source in run
    src_ext = (cur_ff.state == integrity_pkg::SEQ_RUN) & ~ext_s2_ff;
    src_wdg = WDOG_UNDERFLOW_IN;
    start_seq = lvd_act | src_wdg | src_ext;

    // reset sequencer
    nxt_ff.vec_fetch = 1'b0;
    nxt_ff.vec_addr = 16'h0000;
    case (cur_ff.state)
      integrity_pkg::SEQ_RUN: begin
        nxt_ff.act_cnt = '0;
      end
      integrity_pkg::SEQ_ACTIVE: begin
        // stretch to the least output width, longer while supply is low
        if (cur_ff.act_cnt != integrity_pkg::ACT_LAST) begin
          nxt_ff.act_cnt = cur_ff.act_cnt + 1'b1;
        end else if (!lvd_act) begin
          nxt_ff.state = integrity_pkg::SEQ_DELAY;
          nxt_ff.dly_cnt = '0;
        end
      end
      integrity_pkg::SEQ_DELAY: begin
        if (cur_ff.dly_cnt == dly_len(OPT_LONG_DELAY_IN) - 1'b1) begin
          nxt_ff.state = integrity_pkg::SEQ_FETCH;
          nxt_ff.fetch_second = 1'b0;
          nxt_ff.vec_fetch = 1'b1;
          nxt_ff.vec_addr = integrity_pkg::VEC_ADDR_LO;
        end else begin
          nxt_ff.dly_cnt = cur_ff.dly_cnt + 1'b1;
        end
      end
      integrity_pkg::SEQ_FETCH: begin
        // two fetch cycles, then normal execution
        if (!cur_ff.fetch_second) begin
          nxt_ff.fetch_second = 1'b1;
          nxt_ff.vec_fetch = 1'b1;
          nxt_ff.vec_addr = integrity_pkg::VEC_ADDR_HI;
        end else begin
          nxt_ff.state = integrity_pkg::SEQ_RUN;
        end
      end
      default: begin
        nxt_ff.state = integrity_pkg::SEQ_RUN;
      end
    endcase

    // any source restarts the sequence from the active phase
    if (start_seq) begin
      nxt_ff.state = integrity_pkg::SEQ_ACTIVE;
      nxt_ff.act_cnt = '0;
      nxt_ff.vec_fetch = 1'b0;
      nxt_ff.vec_addr = 16'h0000;
      nxt_ff.warn_ie = 1'b0;
      nxt_ff.safe_ie = 1'b0;
    end

    // pin driven low through active and delay phases
    nxt_ff.pin_oe = (nxt_ff.state == integrity_pkg::SEQ_ACTIVE) |
                    (nxt_ff.state == integrity_pkg::SEQ_DELAY);
    nxt_ff.core_rst = (nxt_ff.state != integrity_pkg::SEQ_RUN);

    // clock security: follow the detector, back automatically
    nxt_ff.safe_sel = OPT_CSS_EN_IN & ~cur_ff.clk_s2;

    // bus address phase
    addr_ok = HSEL_IN & HREADY_IN & HTRANS_IN[1];
    status_val = 8'h00;
    status_val[integrity_pkg::WARN_IE_BIT] = cur_ff.warn_ie;
    status_val[integrity_pkg::WARN_FLAG_BIT] = warn_flag;
    status_val[integrity_pkg::LVD_RF_BIT] = cur_ff.lvd_rf;
    status_val[integrity_pkg::SAFE_IE_BIT] = cur_ff.safe_ie;
    status_val[integrity_pkg::SAFE_ACT_BIT] = cur_ff.safe_act & OPT_CSS_EN_IN;
    status_val[integrity_pkg::WDG_RF_BIT] = cur_ff.wdg_rf;
    nxt_ff.wr_pend = addr_ok & HWRITE_IN;
    nxt_ff.wr_hit = addr_ok & HWRITE_IN & reg_hit(HADDR_IN[7:0]);
    if (addr_ok & ~HWRITE_IN & reg_hit(HADDR_IN[7:0])) begin
      nxt_ff.rdata = status_val;
    end else begin
      nxt_ff.rdata = 8'h00;
    end

    // safe clock flag: read clears after recovery, set wins
    if (addr_ok & ~HWRITE_IN & reg_hit(HADDR_IN[7:0]) & cur_ff.clk_s2) begin
      nxt_ff.safe_act = 1'b0;
    end

    // bus data phase: write enables, write zero clears the reset cause flags
    if (cur_ff.wr_hit) begin
      nxt_ff.warn_ie = HWDATA_IN[integrity_pkg::WARN_IE_BIT];
      nxt_ff.safe_ie = HWDATA_IN[integrity_pkg::SAFE_IE_BIT];
      if (!HWDATA_IN[integrity_pkg::LVD_RF_BIT]) begin
        nxt_ff.lvd_rf = 1'b0;
      end
      if (!HWDATA_IN[integrity_pkg::WDG_RF_BIT]) begin
        nxt_ff.wdg_rf = 1'b0;
      end
    end
    if (start_seq) begin
      nxt_ff.warn_ie = 1'b0;
      nxt_ff.safe_ie = 1'b0;
    end

    // reset cause flags, set wins over a write of zero
    if (lvd_act) begin
      nxt_ff.lvd_rf = 1'b1;
      nxt_ff.wdg_rf = 1'b0;
    end else if (src_wdg) begin
      nxt_ff.wdg_rf = 1'b1;
    end

    // hardware sets the flag while the safe clock runs
    if (cur_ff.safe_sel) begin
      nxt_ff.safe_act = 1'b1;
    end
    if (!OPT_CSS_EN_IN) begin
      nxt_ff.safe_act = 1'b0;
    end

    // supply warning request: toggle in run, or enable while flagged
    nxt_ff.warn_prev = warn_flag;
    if (WARN_IRQ_ACK_IN) begin
      nxt_ff.warn_pend = 1'b0;
    end
    if (cur_ff.state != integrity_pkg::SEQ_RUN) begin
      nxt_ff.warn_pend = 1'b0;
    end else if (nxt_ff.warn_ie & (warn_flag != cur_ff.warn_prev)) begin
      nxt_ff.warn_pend = 1'b1;
    end else if (nxt_ff.warn_ie & ~cur_ff.warn_ie & warn_flag) begin
      nxt_ff.warn_pend = 1'b1;
    end
    if (!nxt_ff.warn_ie | ~OPT_LVD_EN_IN) begin
      nxt_ff.warn_pend = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cur_ff <= '{
        state: integrity_pkg::SEQ_ACTIVE,
        act_cnt: '0,
        dly_cnt: '0,
        fetch_second: 1'b0,
        pin_oe: 1'b1,
        core_rst: 1'b1,
        vec_fetch: 1'b0,
        vec_addr: 16'h0000,
        lvd_s1: 1'b0,
        lvd_s2: 1'b0,
        avd_s1: 1'b0,
        avd_s2: 1'b0,
        clk_s1: 1'b1,
        clk_s2: 1'b1,
        wdg_rf: 1'b0,
        lvd_rf: 1'b0,
        warn_ie: 1'b0,
        safe_ie: 1'b0,
        safe_act: 1'b0,
        safe_sel: 1'b0,
        warn_prev: 1'b0,
        warn_pend: 1'b0,
        wr_pend: 1'b0,
        wr_hit: 1'b0,
        rdata: integrity_pkg::INTEGRITY_CTRL_STATUS_RST
      };
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // bus answers: zero wait, always okay, unmapped reads zero
  assign HRDATA_OUT = {24'h000000, cur_ff.rdata};
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;

  // open-drain pin: drive low only
  assign RST_PIN_OUT = 1'b0;
  assign RST_PIN_OE_OUT = cur_ff.pin_oe;

  // core side sequence outputs
  assign CORE_RST_OUT = cur_ff.core_rst;
  assign VEC_FETCH_OUT = cur_ff.vec_fetch;
  assign VEC_ADDR_OUT = cur_ff.vec_addr;

  // interrupts and wake-up
  assign WARN_IRQ_OUT = cur_ff.warn_pend;
  assign SAFE_IRQ_OUT = cur_ff.safe_ie & cur_ff.safe_act &
                        OPT_CSS_EN_IN;
  assign WAKE_OUT = (WARN_IRQ_OUT | SAFE_IRQ_OUT) & ~DEEP_STOP_IN;

  // clock control
  assign SAFE_CLK_SEL_OUT = cur_ff.safe_sel;
  assign GLITCH_FILT_EN_OUT = OPT_PLL_EN_IN;

endmodule // reset_and_integrity_manager

//--- sim/reset_and_integrity_manager_props.sv
/*
  assertions on the ports of reset_and_integrity_manager.
  assumes option straps change only while RSTN_IN is low.
*/
`timescale 1ns/1ps
module integrity_props (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  // sources, straps and detectors
  input wire logic RST_PIN_IN,
  input wire logic WDOG_UNDERFLOW_IN,
  input wire logic LVD_RESET_IN,
  input wire logic OPT_LVD_EN_IN,
  input wire logic OPT_LONG_DELAY_IN,
  input wire logic OPT_CSS_EN_IN,
  input wire logic OPT_PLL_EN_IN,
  input wire logic MAIN_CLK_OK_IN,
  input wire logic DEEP_STOP_IN,
  // watched outputs
  input wire logic RST_PIN_OE_OUT,
  input wire logic CORE_RST_OUT,
  input wire logic VEC_FETCH_OUT,
  input wire logic [15:0] VEC_ADDR_OUT,
  input wire logic WARN_IRQ_OUT,
  input wire logic SAFE_IRQ_OUT,
  input wire logic WAKE_OUT,
  input wire logic SAFE_CLK_SEL_OUT,
  input wire logic GLITCH_FILT_EN_OUT
);
  // ------------------------------------------------
  // helper logic
  // ------------------------------------------------
  int oe_span_ff;
  // consecutive cycles with the pin driven low
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) oe_span_ff <= 0;
    else oe_span_ff <= RST_PIN_OE_OUT ? oe_span_ff + 1 : 0;
  end
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  wdog_start_a: assert property (
    WDOG_UNDERFLOW_IN |=> RST_PIN_OE_OUT && CORE_RST_OUT)
    else $error("underflow did not start a sequence");
  fetch_pair_a: assert property (
    $rose(VEC_FETCH_OUT) |-> VEC_ADDR_OUT == 16'hFFFE ##1
    VEC_FETCH_OUT && VEC_ADDR_OUT == 16'hFFFF ##1 !VEC_FETCH_OUT)
    else $error("vector fetch not two cycles at top pair");
  oe_span_a: assert property (
    $rose(VEC_FETCH_OUT) |-> oe_span_ff >=
    integrity_pkg::RST_OUT_MIN_CYC + (OPT_LONG_DELAY_IN ? 4096 : 256) - 2)
    else $error("pin released too early");
  lvd_hold_a: assert property (
    (OPT_LVD_EN_IN && LVD_RESET_IN)[*4] |-> RST_PIN_OE_OUT)
    else $error("pin not held during low voltage");
  run_holds_a: assert property (
    (!CORE_RST_OUT && !WDOG_UNDERFLOW_IN && RST_PIN_IN &&
    !(OPT_LVD_EN_IN && LVD_RESET_IN))[*4] |=> !CORE_RST_OUT)
    else $error("reset without a source");
  warn_run_a: assert property (
    $rose(WARN_IRQ_OUT) |-> !CORE_RST_OUT)
    else $error("warning request during reset");
  warn_off_a: assert property (
    !OPT_LVD_EN_IN |-> !WARN_IRQ_OUT)
    else $error("warning request without detector option");
  wake_match_a: assert property (
    WAKE_OUT == ((WARN_IRQ_OUT || SAFE_IRQ_OUT) && !DEEP_STOP_IN))
    else $error("wake does not follow requests");
  safe_sel_a: assert property (
    (OPT_CSS_EN_IN && !MAIN_CLK_OK_IN)[*4] |-> SAFE_CLK_SEL_OUT)
    else $error("no switch to safe clock");
  clk_back_a: assert property (
    MAIN_CLK_OK_IN[*4] |-> !SAFE_CLK_SEL_OUT)
    else $error("no switch back to main clock");
  glitch_map_a: assert property (
    $changed(OPT_PLL_EN_IN) || GLITCH_FILT_EN_OUT == OPT_PLL_EN_IN)
    else $error("glitch filter not tied to multiplier");
  safe_irq_a: assert property (
    SAFE_IRQ_OUT |-> OPT_CSS_EN_IN)
    else $error("clock request with security off");
endmodule // integrity_props

bind reset_and_integrity_manager integrity_props i_integrity_props (
  .MCLK_IN(MCLK_IN), .RSTN_IN(RSTN_IN), .RST_PIN_IN(RST_PIN_IN),
  .WDOG_UNDERFLOW_IN(WDOG_UNDERFLOW_IN), .LVD_RESET_IN(LVD_RESET_IN),
  .OPT_LVD_EN_IN(OPT_LVD_EN_IN), .OPT_LONG_DELAY_IN(OPT_LONG_DELAY_IN),
  .OPT_CSS_EN_IN(OPT_CSS_EN_IN), .OPT_PLL_EN_IN(OPT_PLL_EN_IN),
  .MAIN_CLK_OK_IN(MAIN_CLK_OK_IN), .DEEP_STOP_IN(DEEP_STOP_IN),
  .RST_PIN_OE_OUT(RST_PIN_OE_OUT), .CORE_RST_OUT(CORE_RST_OUT),
  .VEC_FETCH_OUT(VEC_FETCH_OUT), .VEC_ADDR_OUT(VEC_ADDR_OUT),
  .WARN_IRQ_OUT(WARN_IRQ_OUT), .SAFE_IRQ_OUT(SAFE_IRQ_OUT),
  .WAKE_OUT(WAKE_OUT), .SAFE_CLK_SEL_OUT(SAFE_CLK_SEL_OUT),
  .GLITCH_FILT_EN_OUT(GLITCH_FILT_EN_OUT));

//--- sim/rst_line_model.sv
/*
  reset line with pull-up and external reset circuitry.
  assumes the device only pulls low through its enable.
*/
`timescale 1ns/1ps
module rst_line_model (
  // device side
  input wire logic oe_in,
  // external circuitry
  input wire logic pull_in,
  output logic level_out
);
  // open-drain wire: low if any party pulls, else pulled up
  assign level_out = !(oe_in || pull_in);
endmodule // rst_line_model

//--- sim/tb_top.sv
/*
  self-checking bench for reset_and_integrity_manager.
  assumes the bound checker and the reset line model beside it.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk, rstn, hsel, hwrite, aux_voltage_detector, clk_ok, ack, dstop;
  logic o_lvd, o_long, o_css, o_pll;
  logic [2:0] src;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic hready, oe, pin, core_rst, vf, warn, sirq, wake, ssel;
  logic [15:0] va;
  int n_errors = 0;
  int tests_run = 0;
  int n;
  reset_and_integrity_manager i_reset_and_integrity_manager (
    .MCLK_IN(clk), .RSTN_IN(rstn), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(), .RST_PIN_IN(pin),
    .RST_PIN_OUT(), .RST_PIN_OE_OUT(oe), .WDOG_UNDERFLOW_IN(src[1]),
    .LVD_RESET_IN(src[2]), .OPT_LVD_EN_IN(o_lvd),
    .OPT_LONG_DELAY_IN(o_long), .OPT_CSS_EN_IN(o_css),
    .OPT_PLL_EN_IN(o_pll), .AVD_CMP_IN(aux_voltage_detector), .MAIN_CLK_OK_IN(clk_ok),
    .WARN_IRQ_ACK_IN(ack), .DEEP_STOP_IN(dstop), .CORE_RST_OUT(core_rst),
    .VEC_FETCH_OUT(vf), .VEC_ADDR_OUT(va), .WARN_IRQ_OUT(warn),
    .SAFE_IRQ_OUT(sirq), .WAKE_OUT(wake), .SAFE_CLK_SEL_OUT(ssel),
    .GLITCH_FILT_EN_OUT());
  rst_line_model i_rst_line_model (.oe_in(oe), .pull_in(src[0]),
    .level_out(pin));
  // ------------------------------------------------
  // clock and shared tasks
  // ------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // counts one comparison and reports a mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one single transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [31:0] a, d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // cycles of pin drive expected for a delay option
  function automatic int span(input logic lng);
    return integrity_pkg::RST_OUT_MIN_CYC + (lng ? 4096 : 256);
  endfunction
  // counts the pin drive of one sequence, then checks the fetch
  task automatic seq(input int lo, input bit ex);
    int c;
    c = 0;
    while (oe !== 1'b1) @(negedge clk);
    while (oe === 1'b1) begin
      c++;
      @(negedge clk);
    end
    chk(32'(c >= lo && (!ex || c == lo)), 32'h1);
    chk({15'h0, vf, va}, 32'h1FFFE);
    @(negedge clk);
    chk({15'h0, vf, va}, 32'h1FFFF);
    @(negedge clk);
    chk(32'({vf, core_rst}), 32'h0);
  endtask
  // raises one reset source for len cycles beside the count
  task automatic run(input int k, input int len, input int lo, input bit ex);
    fork
      seq(lo, ex);
      begin
        @(posedge clk);
        src[k] <= 1'b1;
        repeat (len) @(posedge clk);
        src <= 3'h0;
      end
    join
  endtask
  // prints the counts and the verdict, then ends the run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // cuts a hang short
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    void'($urandom(9));
    {rstn, hsel, hwrite, aux_voltage_detector, ack, dstop, src, htrans} = '0;
    {o_lvd, o_css, o_pll, clk_ok, o_long} = 5'h03;
    {haddr, hwdata} = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    seq(span(1'b1) - 2, 1'b0);
    run(1, 1, span(1'b1), 1'b1);
    bus(1'b0, 32'h0, 32'h0);
    chk(r, 32'h01);
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b0, 32'h0, 32'h0);
    chk(r, 32'h00);
    aux_voltage_detector <= 1'b1;
    clk_ok <= 1'b0;
    // low-voltage source with its option off must not start a sequence
    src[2] <= 1'b1;
    repeat (40) @(posedge clk);
    chk(32'({oe, core_rst}), 32'h0);
    src <= 3'h0;
    n = $urandom_range(1, 63);
    bus(1'b1, 32'(n) << 2, $urandom);
    bus(1'b0, 32'(n) << 2, 32'h0);
    chk(r, 32'h0);
    bus(1'b0, 32'h0, 32'h0);
    chk(r, 32'h00);
    rstn <= 1'b0;
    {o_lvd, o_css, o_pll, o_long, aux_voltage_detector, clk_ok} <= 6'h39;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    seq(span(1'b0) - 2, 1'b0);
    run(0, 3, span(1'b0), 1'b1);
    run(1, 1, span(1'b0), 1'b1);
    bus(1'b0, 32'h0, 32'h0);
    chk(r, 32'h01);
    n = 1200 + $urandom_range(0, 300);
    run(2, n, n, 1'b0);
    bus(1'b0, 32'h0, 32'h0);
    chk(r, 32'h10);
    bus(1'b1, 32'h0, 32'h40);
    aux_voltage_detector <= 1'b1;
    repeat (5) @(posedge clk);
    chk(32'(warn), 32'h1);
    bus(1'b0, 32'h0, 32'h0);
    chk(r, 32'h60);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(posedge clk);
    chk(32'(warn), 32'h0);
    aux_voltage_detector <= 1'b0;
    repeat (5) @(posedge clk);
    chk(32'(warn), 32'h1);
    bus(1'b1, 32'h0, 32'h0);
    aux_voltage_detector <= 1'b1;
    repeat (5) @(posedge clk);
    chk(32'(warn), 32'h0);
    bus(1'b1, 32'h0, 32'h40);
    repeat (2) @(posedge clk);
    chk(32'(warn), 32'h1);
    dstop <= 1'b1;
    @(posedge clk);
    chk(32'(wake), 32'h0);
    dstop <= 1'b0;
    @(posedge clk);
    chk(32'(wake), 32'h1);
    clk_ok <= 1'b0;
    repeat (5) @(posedge clk);
    chk(32'(ssel), 32'h1);
    bus(1'b1, 32'h0, 32'h04);
    repeat (2) @(posedge clk);
    chk(32'(sirq), 32'h1);
    bus(1'b0, 32'h0, 32'h0);
    chk(r, 32'h26);
    clk_ok <= 1'b1;
    repeat (5) @(posedge clk);
    chk(32'(ssel), 32'h0);
    bus(1'b0, 32'h0, 32'h0);
    chk(r & 32'h2, 32'h2);
    bus(1'b0, 32'h0, 32'h0);
    chk(r & 32'h2, 32'h0);
    report_and_stop();
  end
endmodule // tb_top
